// >>> core/dac_power_mode_control.sv
// Power-setting control of a 16-bit converter with APB access
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/10ps
module dac_power_mode_control (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dac_power_pkg::ADDR_W-1:0] paddr,
  input wire logic [dac_power_pkg::DATA_W-1:0] pwdata,
  output logic [dac_power_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmdDone,
  input wire logic [7:0] cmdCtrl,
  input wire logic [7:0] cmdMsb,
  input wire logic [7:0] cmdLsb,
  output logic [15:0] dacCode,
  output dac_power_pkg::setting_type powerSetting,
  output logic ampEnable,
  output logic fastSettle,
  output logic term1k,
  output logic term100k,
  output logic termOpen
);
  import dac_power_pkg::*;

  logic swPending;
  logic [23:0] swWord;
  logic speedSel;
  logic [15:0] tempWord;
  logic tempIsPower;
  setting_type tempSetting;
  logic apbWrite;
  logic apbSetup;
  logic cmdGo;
  logic [7:0] selCtrl;
  logic [7:0] selMsb;
  logic [7:0] selLsb;
  load_type loadSel;
  logic selPd;
  logic doApplySet;
  logic doLoadData;
  logic doStoreTemp;
  setting_type newSet;
  logic [15:0] newData;
  setting_type next_setting;
  logic next_speed;
  logic everLoaded;
  logic everSet;

  // ==========================================================
  // APB slave: one wait-free access phase, answer from flops
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pready && pwrite;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= apbSetup;
      pslverr <= 1'b0;
      prdata <= '0;
      if (apbSetup) begin
        case (paddr)
          OFF_CMD: prdata <= {8'h00, swWord};
          OFF_STATUS: begin
            prdata[ST_SET_LSB +: 3] <= powerSetting;
            prdata[ST_SPEED_BIT] <= speedSel;
            prdata[ST_TSET_LSB +: 3] <= tempSetting;
            prdata[ST_TPWR_BIT] <= tempIsPower;
            prdata[ST_PEND_BIT] <= swPending;
          end
          OFF_DATA: prdata[15:0] <= dacCode;
          OFF_TEMP: prdata[15:0] <= tempWord;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ==========================================================
  // Software command: queued so a serial command never loses it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      swPending <= 1'b0;
      swWord <= '0;
    end else if (apbWrite && paddr == OFF_CMD) begin
      swPending <= 1'b1;
      swWord <= pwdata[23:0];
    end else if (!cmdDone) begin
      swPending <= 1'b0;
    end
  end

  // ==========================================================
  // Command decode; serial path wins over the queued one
  assign cmdGo = cmdDone || swPending;

  always_comb begin
    selCtrl = cmdDone ? cmdCtrl : swWord[CMD_CTRL_LSB +: 8];
    selMsb = cmdDone ? cmdMsb : swWord[CMD_MSB_LSB +: 8];
    selLsb = cmdDone ? cmdLsb : swWord[CMD_LSB_LSB +: 8];
    loadSel = {selCtrl[CTRL_LSH_BIT], selCtrl[CTRL_LSL_BIT]};
    selPd = selCtrl[CTRL_PD_BIT];
    doApplySet = 1'b0;
    doLoadData = 1'b0;
    doStoreTemp = 1'b0;
    // Only the top three bits count; low bits are ignored
    newSet = selMsb[SET_MSB:SET_LSB];
    newData = {selMsb, selLsb};
    case (loadSel)
      LOAD_TEMP: doStoreTemp = 1'b1;
      LOAD_NOW: begin
        doApplySet = selPd;
        doLoadData = !selPd;
        doStoreTemp = !selPd;
      end
      LOAD_FROM_TEMP: begin
        doApplySet = tempIsPower;
        doLoadData = !tempIsPower;
        newSet = tempSetting;
        newData = tempWord;
      end
      default: begin
        if (selCtrl[CTRL_BRC_BIT]) begin
          doApplySet = selPd;
          doLoadData = !selPd;
        end else begin
          doApplySet = tempIsPower;
          doLoadData = !tempIsPower;
          newSet = tempSetting;
          newData = tempWord;
        end
      end
    endcase
    if (!cmdGo) begin
      doApplySet = 1'b0;
      doLoadData = 1'b0;
      doStoreTemp = 1'b0;
    end
  end

  // ==========================================================
  // Temporary register holds either data or a setting
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tempWord <= DATA_RESET;
      tempIsPower <= 1'b0;
      tempSetting <= SET_LOW_POWER;
    end else if (doStoreTemp) begin
      tempIsPower <= selPd;
      if (selPd)
        tempSetting <= newSet;
      else
        tempWord <= newData;
    end
  end

  // ==========================================================
  // Converter data register: never touched by power-down
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      dacCode <= DATA_RESET;
    else if (doLoadData)
      dacCode <= newData;
  end

  // ==========================================================
  // Active setting; cmdDone marks the LS acknowledge end
  always_comb begin
    next_setting = powerSetting;
    next_speed = speedSel;
    if (doApplySet) begin
      next_setting = newSet;
      if (newSet[2:1] == PD_NONE)
        next_speed = newSet[0];
    end else if (doLoadData) begin
      // Leaving power-down restores the last low/fast choice
      next_setting = {PD_NONE, speedSel};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      powerSetting <= SET_LOW_POWER;
      speedSel <= 1'b0;
    end else begin
      powerSetting <= next_setting;
      speedSel <= next_speed;
    end
  end

  dac_setting_decode decode (
    .clk(clk),
    .rstn(rstn),
    .setting(powerSetting),
    .ampEnable(ampEnable),
    .fastSettle(fastSettle),
    .term1k(term1k),
    .term100k(term100k),
    .termOpen(termOpen)
  );

  // ==========================================================
  // Checks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      everLoaded <= 1'b0;
      everSet <= 1'b0;
    end else begin
      everLoaded <= everLoaded || doLoadData;
      everSet <= everSet || doApplySet || doLoadData;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence direct_pd_s;
    cmdDone && cmdCtrl[CTRL_PD_BIT] && !cmdCtrl[CTRL_LSH_BIT]
      && cmdCtrl[CTRL_LSL_BIT];
  endsequence

  sequence store_pd_s;
    cmdDone && cmdCtrl[CTRL_PD_BIT] && !cmdCtrl[CTRL_LSH_BIT]
      && !cmdCtrl[CTRL_LSL_BIT];
  endsequence

  sequence from_temp_s;
    cmdDone && cmdCtrl[CTRL_LSH_BIT] && !cmdCtrl[CTRL_LSL_BIT];
  endsequence

  // Broadcast with the data select low replays the temporary register,
  // which may hold a power-down setting, so it is not a data load
  sequence data_load_s;
    cmdDone && !cmdCtrl[CTRL_PD_BIT] && cmdCtrl[CTRL_LSL_BIT]
      && (!cmdCtrl[CTRL_LSH_BIT] || cmdCtrl[CTRL_BRC_BIT]);
  endsequence

  direct_apply_a: assert property (direct_pd_s |=>
    powerSetting == $past(cmdMsb[SET_MSB:SET_LSB]))
    else $error("direct power setting not applied");
  only_at_ack_a: assert property (!cmdGo |=>
    $stable(powerSetting))
    else $error("power setting changed without command");
  reset_low_a: assert property (!everSet |->
    powerSetting == SET_LOW_POWER)
    else $error("setting left low power without command");
  data_zero_a: assert property (!everLoaded |->
    dacCode == DATA_RESET)
    else $error("data register not zero before load");
  wake_up_a: assert property (data_load_s |=>
    powerSetting[2:1] == PD_NONE)
    else $error("data update left power-down");
  speed_kept_a: assert property (data_load_s |=>
    powerSetting[0] == $past(speedSel))
    else $error("low/fast choice lost on data update");
  code_kept_a: assert property (direct_pd_s |=>
    $stable(dacCode))
    else $error("power-down altered data register");
  temp_store_a: assert property (store_pd_s ##1
    (!cmdGo)[*3] ##1 from_temp_s |=>
    powerSetting == $past(tempSetting) && $stable(dacCode))
    else $error("stored setting not applied from temporary");
  store_only_a: assert property (store_pd_s |=>
    $stable(powerSetting) && tempIsPower)
    else $error("stored setting applied too early");
  bcast_pd_a: assert property (cmdDone && &cmdCtrl[CTRL_LSH_BIT:CTRL_LSL_BIT]
    && cmdCtrl[CTRL_BRC_BIT] && cmdCtrl[CTRL_PD_BIT] |=>
    powerSetting == $past(cmdMsb[SET_MSB:SET_LSB]))
    else $error("broadcast power-down not applied");
  open_term_a: assert property (powerSetting[2:1] == PD_OPEN |=>
    termOpen && !ampEnable && !term1k && !term100k)
    else $error("open termination not selected");
  one_hot_a: assert property (powerSetting[2:1] == PD_1K |=>
    term1k && !ampEnable ##0 $onehot({term1k, term100k, termOpen}))
    else $error("termination controls not one-hot");
  fast_dec_a: assert property (powerSetting == SET_FAST |=>
    fastSettle && ampEnable)
    else $error("fast settling not decoded");
  sw_apply_a: assert property (swPending && !cmdDone
    && swWord[CMD_CTRL_LSB + CTRL_PD_BIT]
    && swWord[CMD_CTRL_LSB + CTRL_LSL_BIT]
    && !swWord[CMD_CTRL_LSB + CTRL_LSH_BIT] |=>
    powerSetting == $past(swWord[CMD_MSB_LSB + SET_LSB +: 3]))
    else $error("queued power setting not applied");
endmodule : dac_power_mode_control

// >>> core/dac_power_pkg.sv
// Constants shared by the converter power-setting control block
package dac_power_pkg;
  // ==========================================================
  // APB register map (byte addresses)
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_TEMP = 8'h0C;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ==========================================================
  // Command word layout in the command register
  localparam int CMD_CTRL_LSB = 16;
  localparam int CMD_MSB_LSB = 8;
  localparam int CMD_LSB_LSB = 0;

  // ==========================================================
  // Control byte fields; setting field of the MSB byte
  localparam int CTRL_PD_BIT = 0;
  localparam int CTRL_BRC_BIT = 2;
  localparam int CTRL_LSL_BIT = 4;
  localparam int CTRL_LSH_BIT = 5;
  localparam int SET_MSB = 7;
  localparam int SET_LSB = 5;

  typedef logic [1:0] load_type;
  localparam load_type LOAD_TEMP = 2'h0;
  localparam load_type LOAD_NOW = 2'h1;
  localparam load_type LOAD_FROM_TEMP = 2'h2;
  localparam load_type LOAD_BCAST = 2'h3;

  // ==========================================================
  // Power settings: top two bits give the termination
  typedef logic [2:0] setting_type;
  localparam setting_type SET_LOW_POWER = 3'h0;
  localparam setting_type SET_FAST = 3'h1;
  localparam logic [1:0] PD_NONE = 2'h0;
  localparam logic [1:0] PD_1K = 2'h1;
  localparam logic [1:0] PD_100K = 2'h2;
  localparam logic [1:0] PD_OPEN = 2'h3;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // ==========================================================
  // Status register fields
  localparam int ST_SET_LSB = 0;
  localparam int ST_SPEED_BIT = 3;
  localparam int ST_TSET_LSB = 4;
  localparam int ST_TPWR_BIT = 7;
  localparam int ST_PEND_BIT = 8;
endpackage : dac_power_pkg

// >>> core/dac_setting_decode.sv
// Registered decode of the power setting into output-stage controls
`timescale 1ns/10ps
module dac_setting_decode (
  input wire logic clk,
  input wire logic rstn,
  input wire dac_power_pkg::setting_type setting,
  output logic ampEnable,
  output logic fastSettle,
  output logic term1k,
  output logic term100k,
  output logic termOpen
);
  import dac_power_pkg::*;

  // ==========================================================
  // One-hot termination in power-down, none in normal use; amplifier is cut off in every power-down
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ampEnable <= 1'b1;
      fastSettle <= 1'b0;
      term1k <= 1'b0;
      term100k <= 1'b0;
      termOpen <= 1'b0;
    end else begin
      ampEnable <= (setting[2:1] == PD_NONE);
      fastSettle <= (setting == SET_FAST);
      term1k <= (setting[2:1] == PD_1K);
      term100k <= (setting[2:1] == PD_100K);
      termOpen <= (setting[2:1] == PD_OPEN);
    end
  end
endmodule : dac_setting_decode

// >>> verification/serial_cmd_model.sv
// Behavioural serial front end that hands over whole write commands
`timescale 1ns/10ps
module serial_cmd_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic req,
  input wire logic [7:0] reqCtrl,
  input wire logic [7:0] reqMsb,
  input wire logic [7:0] reqLsb,
  output logic cmdDone,
  output logic [7:0] cmdCtrl,
  output logic [7:0] cmdMsb,
  output logic [7:0] cmdLsb
);
  // ==========================================================
  // Command delivery
  // Bytes turn over outside a command so stale values never pass
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmdDone <= 1'b0;
      cmdCtrl <= 8'h00;
      cmdMsb <= 8'h00;
      cmdLsb <= 8'h00;
    end else if (req) begin
      cmdDone <= 1'b1;
      cmdCtrl <= reqCtrl;
      cmdMsb <= reqCtrl[0] ? {reqMsb[7:5], 5'h00} : reqMsb;
      cmdLsb <= reqCtrl[0] ? 8'h00 : reqLsb;
    end else begin
      cmdDone <= 1'b0;
      cmdCtrl <= ~cmdCtrl;
      cmdMsb <= ~cmdMsb;
      cmdLsb <= ~cmdLsb;
    end
  end
endmodule : serial_cmd_model

// >>> verification/dac_power_mode_control_tb.sv
// Self-checking bench for the converter power-setting control
`timescale 1ns/10ps
module dac_power_mode_control_tb;
  import dac_power_pkg::*;
  // ==========================================================
  // Signals
  logic clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic req, cmdDone, ampEnable, fastSettle, term1k, term100k, termOpen;
  logic [7:0] rCtrl, rMsb, rLsb, cmdCtrl, cmdMsb, cmdLsb;
  logic [15:0] dacCode;
  setting_type powerSetting;
  logic [32:0] expQ [$];
  logic [31:0] maskQ [$];
  logic [2:0] sv [5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h7};
  logic [31:0] d;
  int seed, mismatches, num_checks;

  dac_power_mode_control dut (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmdDone(cmdDone), .cmdCtrl(cmdCtrl), .cmdMsb(cmdMsb),
    .cmdLsb(cmdLsb), .dacCode(dacCode), .powerSetting(powerSetting),
    .ampEnable(ampEnable), .fastSettle(fastSettle), .term1k(term1k),
    .term100k(term100k), .termOpen(termOpen));

  serial_cmd_model far (.clk(clk), .rstn(rstn), .req(req),
    .reqCtrl(rCtrl), .reqMsb(rMsb), .reqLsb(rLsb), .cmdDone(cmdDone),
    .cmdCtrl(cmdCtrl), .cmdMsb(cmdMsb), .cmdLsb(cmdLsb));

  // ==========================================================
  // Checking
  task check(input logic [32:0] s, input logic [32:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check

  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  function automatic logic [4:0] dec(input logic [2:0] s);
    case (s[2:1])
      2'h0: dec = {1'b1, s[0], 3'h0};
      2'h1: dec = 5'h04;
      2'h2: dec = 5'h02;
      default: dec = 5'h01;
    endcase
  endfunction : dec

  task outs(input logic [2:0] s, input logic [15:0] v);
    check({9'h000, dacCode, powerSetting, ampEnable, fastSettle, term1k,
      term100k, termOpen}, {9'h000, v, s, dec(s)});
  endtask : outs

  // Read results are noted here and compared by the monitor below
  task apb(input logic w, input logic [7:0] a, input logic [31:0] v,
           input logic [31:0] m, input logic e);
    expQ.push_back({e, v & m});
    maskQ.push_back(m);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      check({pslverr, prdata & maskQ[0]}, expQ[0]);
      void'(maskQ.pop_front());
      void'(expQ.pop_front());
    end
  end

  task cmd(input logic [7:0] c, input logic [7:0] m, input logic [7:0] l);
    logic [2:0] prev;
    prev = powerSetting;
    req <= 1'b1;
    rCtrl <= c;
    rMsb <= m;
    rLsb <= l;
    @(posedge clk);
    req <= 1'b0;
    @(negedge clk);
    check({30'h0, powerSetting}, {30'h0, prev});
    @(posedge clk);
    repeat (2) @(posedge clk);
  endtask : cmd

  // ==========================================================
  // Stimulus
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    #50000;
    mismatches++;
    complete_run;
  end

  initial begin
    seed = 6101;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    req = 1'b0;
    rCtrl = 8'h00;
    rMsb = 8'h00;
    rLsb = 8'h00;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    outs(3'h0, 16'h0000);
    $display("Test reset done");
    d = $random(seed);
    cmd(8'h10, d[15:8], d[7:0]);
    outs(3'h0, d[15:0]);
    for (int i = 0; i < 5; i++) begin
      cmd(8'h11, {sv[i], 5'h00}, 8'h00);
      outs(sv[i], d[15:0]);
      apb(1'b0, OFF_STATUS, {29'h0, sv[i]}, 32'h7, 1'b0);
    end
    $display("Test settings done");
    d = $random(seed);
    cmd(8'h10, d[15:8], d[7:0]);
    outs(3'h1, d[15:0]);
    cmd(8'h01, 8'h80, 8'h00);
    outs(3'h1, d[15:0]);
    cmd(8'h20, 8'h00, 8'h00);
    outs(3'h4, d[15:0]);
    $display("Test temporary done");
    cmd(8'h35, 8'hC0, 8'h00);
    outs(3'h6, d[15:0]);
    d = $random(seed);
    cmd(8'h34, d[15:8], d[7:0]);
    outs(3'h1, d[15:0]);
    $display("Test broadcast done");
    apb(1'b1, OFF_CMD, 32'h0011_4000, 32'h0, 1'b0);
    repeat (2) @(posedge clk);
    outs(3'h2, d[15:0]);
    apb(1'b0, OFF_STATUS, 32'h0000_00CA, 32'h0000_01FF, 1'b0);
    apb(1'b0, OFF_CMD, 32'h0011_4000, 32'hFFFF_FFFF, 1'b0);
    apb(1'b0, OFF_DATA, {16'h0, d[15:0]}, 32'hFFFF, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 32'hFFFF_FFFF, 1'b1);
    $display("Test register access done");
    repeat (2) @(posedge clk);
    complete_run;
  end
endmodule : dac_power_mode_control_tb
